// ===== logic/bam_params.svh
/*
 board address and interrupt map constants: window bases, masks,
 polarities, serial defaults. assumes 32-bit byte addresses.
*/
`ifndef BAM_PARAMS_SVH
`define BAM_PARAMS_SVH
`define BAM_SDRAM_BASE     32'h0000_0000
`define BAM_SDRAM_MASK     32'hfc00_0000
`define BAM_FIRST_BUS_CONTROLLER_CHANNEL_BASE      32'hf000_0000
`define BAM_SECOND_BUS_CONTROLLER_CHANNEL_BASE      32'hf000_0100
`define BAM_CAN_MASK       32'hffff_ff80
`define BAM_IDE_BASE       32'hf010_0000
`define BAM_IDE_MASK       32'hffff_ffe0
`define BAM_NV_BASE        32'hf020_0000
`define BAM_NV_MASK        32'hffff_8000
`define BAM_NV_USER_END    32'hf020_5fff
`define BAM_NV_RSVD_BASE   32'hf020_6000
`define BAM_NV_ENV_BASE    32'hf020_7000
`define BAM_NV_RTC_BASE    32'hf020_7ff8
`define BAM_FPGA_BASE      32'hf040_0000
`define BAM_FPGA_MASK      32'hfff0_0000
`define BAM_SWITCH_ADDR    32'hf040_0002
`define BAM_FLASH0_BASE    32'hffc0_0000
`define BAM_FLASH1_BASE    32'hffe0_0000
`define BAM_FLASH_MASK     32'hffe0_0000
`define BAM_IRQ_ACT_LOW    7'h33
`define BAM_REG_BAUD       8'h00
`define BAM_REG_FRAME      8'h04
`define BAM_REG_IRQ_STAT   8'h08
`define BAM_REG_IRQ_MASK   8'h0c
`define BAM_REG_STRAP      8'h10
`define BAM_BAUD_DEFAULT   18'h02580
`define BAM_BAUD_MAX       18'h1c200
`define BAM_FRAME_DEFAULT  12'h008
`define BAM_IRQ_RESET      7'h00
`define BAM_RDATA_IDLE     32'h0000_0000
`define BAM_STRAP_RESET    2'b00
`define BAM_CNT_RESET      16'h0000
`endif

// ===== logic/bam_pkg.sv
/*
 types for the board address map block.
 assumes bam_params.svh is available.
*/
`default_nettype none
package bam_pkg;
	typedef struct packed {
		logic sdram;
		logic first_bus_controller_channel;
		logic second_bus_controller_channel;
		logic ide;
		logic nv_user;
		logic nv_rsvd;
		logic nv_env;
		logic nv_rtc;
		logic fpga;
		logic switches;
		logic flash0;
		logic flash1;
	} bam_sel_t;
	typedef struct packed {
		logic [7:0] stop_parity_flow;
		logic [3:0] data_bits;
	} bam_frame_t;
	typedef enum logic [1:0] {
		BAM_BOOT   = 2'b00,
		BAM_STRAP  = 2'b01,
		BAM_RUN    = 2'b10
	} bam_state_t;
endpackage
`default_nettype wire

// ===== logic/bam_top.sv
/*
 board glue: local-bus address decode, external interrupt polarity,
 serial port defaults and boot strap release.
 assumes address is stable while the core asserts bus_valid.
*/
`include "bam_params.svh"
`timescale 1ns/1ps
`default_nettype none
module bam_top #(
	parameter int STRAP_CYCLES = 16
) (
	input  wire logic              clk_sys,
	input  wire logic              rstn,
	input  wire logic [31:0]       bus_addr,
	input  wire logic              bus_valid,
	output var  bam_pkg::bam_sel_t bus_sel,
	output logic                   bus_unmapped,
	input  wire logic [3:0]        coding_switch,
	output logic [7:0]             switch_rdata,
	input  wire logic [6:0]        irq_pin,
	output logic [6:0]             external_interrupt_input,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [31:0]            reg_rdata,
	output logic                   irq,
	output logic [17:0]            rs232_serial_port_baud,
	output logic [17:0]            ttl_serial_port_baud,
	output var  bam_pkg::bam_frame_t serial_frame,
	input  wire logic              ttl_port_transmit_strap_i,
	input  wire logic              ttl_port_handshake_strap_i,
	input  wire logic              ttl_tx,
	input  wire logic              ttl_rts,
	output logic                   ttl_port_transmit_strap_o,
	output logic                   ttl_port_transmit_strap_oe_n,
	output logic                   ttl_port_handshake_strap_o,
	output logic                   ttl_port_handshake_strap_oe_n,
	output logic                   boot_done
);
	localparam int IRQ_LINES = 7;

	// one comparator shape serves every masked window; the switch byte is a plain equality
	function automatic logic hit(
		input logic [31:0] a,
		input logic [31:0] b,
		input logic [31:0] m
	);
		hit = (a & m) == b;
	endfunction

	// offset match, shared by the write and the read decode
	function automatic logic reg_is(
		input logic [7:0] a,
		input logic [7:0] o
	);
		reg_is = a == o;
	endfunction

	// raw window matches, qualified by bus_valid further down
	wire logic sdram_hit  = hit(bus_addr, `BAM_SDRAM_BASE, `BAM_SDRAM_MASK);
	wire logic first_bus_controller_channel_hit   = hit(bus_addr, `BAM_FIRST_BUS_CONTROLLER_CHANNEL_BASE, `BAM_CAN_MASK);
	wire logic second_bus_controller_channel_hit   = hit(bus_addr, `BAM_SECOND_BUS_CONTROLLER_CHANNEL_BASE, `BAM_CAN_MASK);
	wire logic ide_hit    = hit(bus_addr, `BAM_IDE_BASE, `BAM_IDE_MASK);
	wire logic nv_hit     = hit(bus_addr, `BAM_NV_BASE, `BAM_NV_MASK);
	wire logic fpga_win   = hit(bus_addr, `BAM_FPGA_BASE, `BAM_FPGA_MASK);
	wire logic sw_hit     = bus_addr == `BAM_SWITCH_ADDR;
	wire logic flash0_hit = hit(bus_addr, `BAM_FLASH0_BASE, `BAM_FLASH_MASK);
	wire logic flash1_hit = hit(bus_addr, `BAM_FLASH1_BASE, `BAM_FLASH_MASK);

	// battery backed memory, split into its four areas
	wire logic nv_user_hit = nv_hit && bus_addr <= `BAM_NV_USER_END;
	wire logic nv_rsvd_hit = nv_hit && bus_addr >= `BAM_NV_RSVD_BASE
		&& bus_addr < `BAM_NV_ENV_BASE;
	// clock registers overlay the env top, so the clock wins there
	wire logic nv_rtc_hit  = nv_hit && bus_addr >= `BAM_NV_RTC_BASE;
	wire logic nv_env_hit  = nv_hit && bus_addr >= `BAM_NV_ENV_BASE
		&& !nv_rtc_hit;
	// switch byte carved out, so two selects never fire together
	wire logic fpga_hit    = fpga_win && !sw_hit;

	assign bus_sel = '{
		sdram:    bus_valid && sdram_hit,
		first_bus_controller_channel:     bus_valid && first_bus_controller_channel_hit,
		second_bus_controller_channel:     bus_valid && second_bus_controller_channel_hit,
		ide:      bus_valid && ide_hit,
		nv_user:  bus_valid && nv_user_hit,
		nv_rsvd:  bus_valid && nv_rsvd_hit,
		nv_env:   bus_valid && nv_env_hit,
		nv_rtc:   bus_valid && nv_rtc_hit,
		fpga:     bus_valid && fpga_hit,
		switches: bus_valid && sw_hit,
		flash0:   bus_valid && flash0_hit,
		flash1:   bus_valid && flash1_hit
	};
	wire logic any_hit = |bus_sel;
	assign bus_unmapped = bus_valid && !any_hit;
	assign switch_rdata = {4'h0, coding_switch};

	// every line reaches the core active high, whatever its pin polarity
	wire logic [6:0] irq_level = irq_pin ^ `BAM_IRQ_ACT_LOW;
	assign external_interrupt_input = irq_level;

	logic [17:0]         baud [2];
	logic [11:0]         frame;
	logic [6:0]          irq_stat;
	logic [6:0]          irq_mask;
	logic [1:0]          strap_val;
	logic [15:0]         strap_cnt;
	bam_pkg::bam_state_t state;
	bam_pkg::bam_state_t next_state;

	wire logic wr_baud  = reg_wr && reg_is(reg_addr, `BAM_REG_BAUD);
	wire logic wr_frame = reg_wr && reg_is(reg_addr, `BAM_REG_FRAME);
	wire logic wr_stat  = reg_wr && reg_is(reg_addr, `BAM_REG_IRQ_STAT);
	wire logic wr_mask  = reg_wr && reg_is(reg_addr, `BAM_REG_IRQ_MASK);

	// out-of-range rates ignored rather than clipped, so the link stays usable
	wire logic baud_ok = reg_wdata[17:0] != 18'h0
		&& reg_wdata[17:0] <= `BAM_BAUD_MAX;
	// bit 31 picks the port: 0 rs232, 1 ttl
	wire logic [1:0] baud_we = {wr_baud && baud_ok && reg_wdata[31],
		wr_baud && baud_ok && !reg_wdata[31]};
	wire logic [6:0] stat_clr = wr_stat ? reg_wdata[6:0] : 7'h00;
	wire logic [6:0] next_stat;

	for (genvar p = 0; p < 2; p++) begin : g_port
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn)
				baud[p] <= `BAM_BAUD_DEFAULT;
			else if (baud_we[p])
				baud[p] <= reg_wdata[17:0];
		end
	end

	// a live line beats a clear landing in the same cycle
	for (genvar g = 0; g < IRQ_LINES; g++) begin : g_line
		assign next_stat[g] = irq_level[g] | (irq_stat[g] & ~stat_clr[g]);
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			frame <= `BAM_FRAME_DEFAULT;
		else if (wr_frame)
			frame <= reg_wdata[11:0];
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			irq_stat <= `BAM_IRQ_RESET;
		else
			irq_stat <= next_stat;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			irq_mask <= `BAM_IRQ_RESET;
		else if (wr_mask)
			irq_mask <= reg_wdata[6:0];
	end

	// strap pins stay released until the boot window has closed
	wire logic boot_over = strap_cnt == 16'(STRAP_CYCLES - 1);

	always_comb begin
		next_state = state;
		unique case (state)
			bam_pkg::BAM_BOOT: begin
				if (boot_over)
					next_state = bam_pkg::BAM_STRAP;
			end
			bam_pkg::BAM_STRAP: begin
				next_state = bam_pkg::BAM_RUN;
			end
			bam_pkg::BAM_RUN: begin
				next_state = bam_pkg::BAM_RUN;
			end
			// the fourth code is unused; fall back to a fresh boot
			default: begin
				next_state = bam_pkg::BAM_BOOT;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			state <= bam_pkg::BAM_BOOT;
		else
			state <= next_state;
	end

	// limitation: boot windows beyond 16 bits of count wrap around
	wire logic in_boot = state == bam_pkg::BAM_BOOT;
	wire logic [15:0] next_cnt = in_boot ? strap_cnt + 16'h0001 : strap_cnt;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			strap_cnt <= `BAM_CNT_RESET;
		else
			strap_cnt <= next_cnt;
	end

	// lines are still released here, so only the board resistors set them
	wire logic take_strap = state == bam_pkg::BAM_STRAP;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			strap_val <= `BAM_STRAP_RESET;
		else if (take_strap)
			strap_val <= {ttl_port_handshake_strap_i, ttl_port_transmit_strap_i};
	end

	wire logic run = state == bam_pkg::BAM_RUN;
	assign boot_done = run;
	assign ttl_port_transmit_strap_o = ttl_tx;
	assign ttl_port_handshake_strap_o = ttl_rts;
	assign ttl_port_transmit_strap_oe_n = !run;
	assign ttl_port_handshake_strap_oe_n = !run;

	assign rs232_serial_port_baud = baud[0];
	assign ttl_serial_port_baud = baud[1];
	assign serial_frame = frame;
	assign irq = |(irq_stat & irq_mask);

	// only bits 17:10 of the ttl rate fit beside the full rs232 rate
	wire logic [31:0] rd_word =
		reg_is(reg_addr, `BAM_REG_BAUD)     ? {6'h00, baud[1][17:10], baud[0]} :
		reg_is(reg_addr, `BAM_REG_FRAME)    ? {20'h00000, frame} :
		reg_is(reg_addr, `BAM_REG_IRQ_STAT) ? {25'h0000000, irq_stat} :
		reg_is(reg_addr, `BAM_REG_IRQ_MASK) ? {25'h0000000, irq_mask} :
		reg_is(reg_addr, `BAM_REG_STRAP)    ? {29'h00000000, run, strap_val} :
		`BAM_RDATA_IDLE;
	// data stands for one cycle only, zero otherwise
	wire logic [31:0] next_rdata = reg_rd ? rd_word : `BAM_RDATA_IDLE;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			reg_rdata <= `BAM_RDATA_IDLE;
		else
			reg_rdata <= next_rdata;
	end
endmodule
`default_nettype wire

// ===== testbench/bam_strap_model.sv
/*
 strap line model: board pull resistor plus the processor pad.
 assumes oe_n high means the pad is released.
*/
`timescale 1ns/1ps
`default_nettype none
module bam_strap_model #(
	parameter logic PULL = 1'b1
) (
	input  wire logic oe_n,
	input  wire logic drv,
	output logic      line
);
	// released pad rests at the resistor level, never the last value
	assign line = oe_n ? PULL : drv;
endmodule
`default_nettype wire

// ===== testbench/bam_checker.sv
/*
 port checker for bam_top.
 assumes one clock domain and the bind below.
*/
`timescale 1ns/1ps
`default_nettype none
module bam_checker (
	input wire logic              clk_sys,
	input wire logic              rstn,
	input wire logic [31:0]       bus_addr,
	input wire logic              bus_valid,
	input wire bam_pkg::bam_sel_t bus_sel,
	input wire logic              bus_unmapped,
	input wire logic [3:0]        coding_switch,
	input wire logic [7:0]        switch_rdata,
	input wire logic [6:0]        irq_pin,
	input wire logic [6:0]        external_interrupt_input,
	input wire logic [7:0]        reg_addr,
	input wire logic [31:0]       reg_wdata,
	input wire logic              reg_wr,
	input wire logic [17:0]       rs232_serial_port_baud,
	input wire bam_pkg::bam_frame_t serial_frame,
	input wire logic              boot_done,
	input wire logic              ttl_port_transmit_strap_oe_n,
	input wire logic              ttl_port_handshake_strap_oe_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	a_sdram_hit: assert property (bus_valid && bus_addr < 32'h0400_0000
		|-> bus_sel.sdram && !bus_unmapped) else $error("sdram decode");
	a_rtc_top: assert property (bus_valid && bus_addr[31:3] == 29'h1e04_0fff
		|-> bus_sel.nv_rtc) else $error("rtc decode");
	a_switch_byte: assert property (switch_rdata == {4'h0, coding_switch})
		else $error("switch byte");
	a_irq_norm: assert property (external_interrupt_input == (irq_pin ^ 7'h33))
		else $error("irq polarity");
	a_frame_fixed: assert property (serial_frame == 12'h008) else $error("frame");
	a_baud_write: assert property (reg_wr && reg_addr == 8'h00 && reg_wdata[31:18] == 14'h0
		&& reg_wdata[17:0] inside {[18'h1:18'h1c200]}
		|=> rs232_serial_port_baud == $past(reg_wdata[17:0])) else $error("baud write");
	a_refuse_zero: assert property (reg_wr && reg_addr == 8'h00 && reg_wdata == 32'h0
		|=> $stable(rs232_serial_port_baud)) else $error("baud zero taken");
	a_strap_float: assert property (!boot_done |-> ttl_port_transmit_strap_oe_n
		&& ttl_port_handshake_strap_oe_n) else $error("strap driven in boot");
	a_unmapped_gap: assert property (bus_valid && bus_addr >= 32'h0400_0000
		&& bus_addr < 32'hf000_0000 |-> bus_unmapped) else $error("gap decoded");
endmodule
bind bam_top bam_checker i_chk (.*);
`default_nettype wire

// ===== testbench/board_address_irq_map_tb.sv
/*
 self-checking bench for bam_top with strap pull models.
 assumes bam_pkg is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module board_address_irq_map_tb;
	logic clk_sys, rstn, bus_valid, bus_unmapped, reg_wr, reg_rd, irq, ttl_tx, ttl_rts;
	logic boot_done, ttl_port_transmit_strap_i, ttl_port_handshake_strap_i;
	logic ttl_port_transmit_strap_o, ttl_port_transmit_strap_oe_n;
	logic ttl_port_handshake_strap_o, ttl_port_handshake_strap_oe_n, was_rd;
	logic [31:0] bus_addr, reg_wdata, reg_rdata;
	logic [7:0]  reg_addr, switch_rdata;
	logic [6:0]  irq_pin, external_interrupt_input;
	logic [3:0]  coding_switch;
	logic [17:0] rs232_serial_port_baud, ttl_serial_port_baud;
	bam_pkg::bam_sel_t   bus_sel;
	bam_pkg::bam_frame_t serial_frame;
	logic [31:0] q[$];
	int mismatches = 0, n_compared = 0;
	localparam logic [31:0] A [14] = '{32'h03ff_ffff, 32'hf000_007f, 32'hf000_0100,
		32'hf010_001f, 32'hf020_5fff, 32'hf020_7000, 32'hf020_7ff8, 32'hf040_0002,
		32'hf04f_ffff, 32'hffdf_ffff, 32'hffe0_0000, 32'hf000_0080, 32'hf020_6000,
		32'h0400_0000};
	localparam logic [11:0] S [14] = '{12'h800, 12'h400, 12'h200, 12'h100, 12'h080,
		12'h020, 12'h010, 12'h004, 12'h008, 12'h002, 12'h001, 12'h000, 12'h040,
		12'h000};
	bam_top #(.STRAP_CYCLES(2)) i_dut (
		.clk_sys                       (clk_sys),
		.rstn                          (rstn),
		.bus_addr                      (bus_addr),
		.bus_valid                     (bus_valid),
		.bus_sel                       (bus_sel),
		.bus_unmapped                  (bus_unmapped),
		.coding_switch                 (coding_switch),
		.switch_rdata                  (switch_rdata),
		.irq_pin                       (irq_pin),
		.external_interrupt_input      (external_interrupt_input),
		.reg_addr                      (reg_addr),
		.reg_wdata                     (reg_wdata),
		.reg_wr                        (reg_wr),
		.reg_rd                        (reg_rd),
		.reg_rdata                     (reg_rdata),
		.irq                           (irq),
		.rs232_serial_port_baud        (rs232_serial_port_baud),
		.ttl_serial_port_baud          (ttl_serial_port_baud),
		.serial_frame                  (serial_frame),
		.ttl_port_transmit_strap_i     (ttl_port_transmit_strap_i),
		.ttl_port_handshake_strap_i    (ttl_port_handshake_strap_i),
		.ttl_tx                        (ttl_tx),
		.ttl_rts                       (ttl_rts),
		.ttl_port_transmit_strap_o     (ttl_port_transmit_strap_o),
		.ttl_port_transmit_strap_oe_n  (ttl_port_transmit_strap_oe_n),
		.ttl_port_handshake_strap_o    (ttl_port_handshake_strap_o),
		.ttl_port_handshake_strap_oe_n (ttl_port_handshake_strap_oe_n),
		.boot_done                     (boot_done)
	);
	bam_strap_model #(.PULL(1'b1)) i_tx (.oe_n(ttl_port_transmit_strap_oe_n),
		.drv(ttl_port_transmit_strap_o), .line(ttl_port_transmit_strap_i));
	bam_strap_model #(.PULL(1'b0)) i_hs (.oe_n(ttl_port_handshake_strap_oe_n),
		.drv(ttl_port_handshake_strap_o), .line(ttl_port_handshake_strap_i));
	initial begin
		clk_sys = 0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic end_sim;
		$display("counts: %0d mismatches in %0d compares", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic op(logic w, logic r, logic [7:0] a, logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		op(1, 0, a, d);
		op(0, 0, 0, 0);
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] e);
		q.push_back(e);
		op(0, 1, a, 0);
		op(0, 0, 0, 0);
	endtask
	// read data stands only in the cycle after the strobe
	always @(posedge clk_sys) begin
		if (was_rd)
			chk("reg_rdata", reg_rdata, q.pop_front());
		was_rd <= reg_rd;
	end
	initial begin
		#200000;
		mismatches++;
		end_sim();
	end
	initial begin
		{rstn, bus_valid, reg_wr, reg_rd, ttl_tx, ttl_rts, was_rd} = '0;
		{bus_addr, reg_wdata, reg_addr, coding_switch} = '0;
		irq_pin = 7'h33;
		void'($urandom(14));
		repeat (4) @(posedge clk_sys);
		rstn <= 1'b1;
		@(negedge clk_sys) chk("oe_n", ttl_port_transmit_strap_oe_n, 1);
		repeat (20) if (!boot_done) @(posedge clk_sys);
		@(posedge clk_sys) {ttl_tx, ttl_rts} <= 2'($urandom);
		@(negedge clk_sys) begin
			chk("oe_n_run", ttl_port_handshake_strap_oe_n, 0);
			chk("tx_line", ttl_port_transmit_strap_i, ttl_tx);
			chk("rts_line", ttl_port_handshake_strap_i, ttl_rts);
		end
		rd(8'h10, 32'h5);
		rd(8'h00, 32'h0024_2580);
		rd(8'h04, 32'h8);
		wr(8'h00, 32'h0001_c200);
		wr(8'h00, 32'h0);
		wr(8'h00, 32'h0001_c201);
		@(negedge clk_sys) chk("rs232_baud", rs232_serial_port_baud, 32'h0001_c200);
		rd(8'h00, 32'h0025_c200);
		wr(8'h00, 32'h8001_c200);
		@(negedge clk_sys) chk("ttl_baud", ttl_serial_port_baud, 32'h0001_c200);
		rd(8'h00, 32'h01c1_c200);
		rd(8'h40, 32'h0);
		for (int i = 0; i < 7; i++) begin
			@(posedge clk_sys) irq_pin <= 7'h33 ^ (7'h1 << i);
			wr(8'h0c, i[0] ? 32'h0 : 32'h1 << i);
			rd(8'h08, 32'h1 << i);
			@(negedge clk_sys) chk("irq", irq, !i[0]);
			@(posedge clk_sys) irq_pin <= 7'h33;
			wr(8'h08, 32'h1 << i);
			@(negedge clk_sys) chk("irq_clr", irq, 0);
		end
		for (int i = 0; i < 14; i++) begin
			@(posedge clk_sys) begin
				bus_valid <= 1'b1;
				bus_addr <= A[i];
				coding_switch <= 4'($urandom);
			end
			@(negedge clk_sys) begin
				chk("bus_sel", 32'(bus_sel), 32'(S[i]));
				chk("unmapped", bus_unmapped, S[i] == 12'h000);
				chk("switch", switch_rdata, {4'h0, coding_switch});
			end
		end
		// second reset in mid-run: defaults come back, pads released again
		@(posedge clk_sys) rstn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		rd(8'h00, 32'h0024_2580);
		@(negedge clk_sys) chk("oe_n_reset", ttl_port_transmit_strap_oe_n, 1);
		repeat (3) @(posedge clk_sys);
		end_sim();
	end
endmodule
`default_nettype wire
